//--- lmr_pkg.sv
// package: offsets, reset values, selector codes and timing for the load model block
package lmr_pkg;
  localparam logic [6:0] LMR_OFF_SELECTOR = 7'h00;
  localparam logic [6:0] LMR_OFF_KIND = 7'h01;
  localparam logic [6:0] LMR_OFF_RISE = 7'h11;
  localparam logic [6:0] LMR_OFF_FALL = 7'h12;
  localparam logic [6:0] LMR_OFF_WEIGHT_LO = 7'h14;
  localparam logic [6:0] LMR_OFF_WEIGHT_HI = 7'h15;
  localparam logic [7:0] LMR_RST_SELECTOR = 8'h01;
  localparam logic [7:0] LMR_RST_KIND = 8'h01;
  localparam logic [7:0] LMR_RST_RISE = 8'h0F;
  localparam logic [7:0] LMR_RST_FALL = 8'h05;
  localparam logic [15:0] LMR_RST_WEIGHT = 16'h0320;
  localparam logic [15:0] LMR_WEIGHT_FULL = 16'h03E8;
  localparam logic [7:0] LMR_FACTOR_DIV = 8'h0A;
  localparam logic [7:0] LMR_RATE_DIV = 8'h05;
  localparam logic [2:0] LMR_SEL_PREV = 3'h0;
  localparam logic [2:0] LMR_SEL_RUN = 3'h1;
  localparam logic [2:0] LMR_SEL_MEAN = 3'h2;
  localparam logic [2:0] LMR_SEL_FILT = 3'h3;
  localparam logic [2:0] LMR_SEL_DESIGN = 3'h4;
  localparam logic [2:0] LMR_SEL_HOST = 3'h5;
  localparam logic [2:0] LMR_SEL_USER = 3'h6;
  localparam int LMR_CLK_MHZ = 250;
  localparam int LMR_RESIM_S = 500;
  localparam longint LMR_RESIM_CYC = longint'(LMR_RESIM_S) * LMR_CLK_MHZ * 1000000;
  localparam int LMR_FILT_TAU_S = 14;
  typedef enum logic [1:0] {
    LMR_ST_IDLE = 2'b00,
    LMR_ST_CALC = 2'b01,
    LMR_ST_DONE = 2'b10
  } lmr_state_t;
endpackage

//--- lmr_load_model.sv
// load model selection and resistance update arithmetic
module lmr_load_model
  import lmr_pkg::*;
#(
  parameter int DW = 16,
  parameter longint RESIM_CYC = LMR_RESIM_CYC,
  parameter int FILT_SHIFT = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_wr,
  input wire logic [6:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic load_kind_flag,
  input wire logic discharging,
  input wire logic sample_valid,
  input wire logic [DW-1:0] mean_current_reading,
  input wire logic [DW-1:0] voltage_reading,
  input wire logic [DW-1:0] design_capacity,
  input wire logic [DW-1:0] design_energy,
  input wire logic [DW-1:0] host_load_setting,
  input wire logic [DW-1:0] user_current_setting,
  input wire logic [DW-1:0] user_power_setting,
  output logic [DW-1:0] sim_load,
  output logic resim_pulse,
  output logic [DW-1:0] last_run_current,
  output logic [DW-1:0] last_run_power,
  input wire logic res_start,
  input wire logic [DW-1:0] res_old,
  input wire logic [DW-1:0] res_new,
  output logic [DW-1:0] res_result,
  output logic res_done
);

  ////////////////////////////////////////////////////////////////////////////
  // internal widths
  // products of two data words need twice the data width; the averaging
  // accumulators get 32 spare bits on top so that a long discharge of full
  // scale samples cannot wrap before the sample counter saturates
  localparam int PW = 2 * DW;
  localparam int AW = PW + 32;
  // the filter keeps FILT_SHIFT fraction bits, otherwise a step smaller than
  // one part in 2**FILT_SHIFT would never reach the output
  localparam int FW = DW + FILT_SHIFT;

  ////////////////////////////////////////////////////////////////////////////
  // all state of the block lives in one packed record, registered once
  typedef struct packed {
    logic [7:0] selector;
    logic [7:0] kind;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [15:0] weight;
    logic [7:0] rdata;
    logic [FW-1:0] filt; // filter state with fraction bits
    logic [AW-1:0] acc_i;
    logic [AW-1:0] acc_p;
    logic [31:0] n_samp;
    logic [63:0] dis_cnt;
    logic live;
    logic was_dis;
    logic [DW-1:0] last_i;
    logic [DW-1:0] last_p;
    logic [DW-1:0] load;
    logic resim;
    lmr_state_t st;
    logic [DW-1:0] old_q;
    logic [DW-1:0] new_q;
    logic [DW-1:0] result;
    logic done;
  } lmr_regs_t;

  lmr_regs_t r_r;
  lmr_regs_t r_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helper arithmetic
  // unsigned truncating division of a wide value, cut to the data width;
  // a zero divisor gives zero rather than an unknown, and an oversized
  // quotient saturates instead of silently losing its upper bits
  function automatic logic [DW-1:0] lmr_div(input logic [AW-1:0] num, input logic [AW-1:0] den);
    logic [AW-1:0] q;
    q = (den == '0) ? '0 : num / den;
    return (q > AW'({DW{1'b1}})) ? {DW{1'b1}} : q[DW-1:0];
  endfunction

  // product of two data words scaled back by the power fraction width;
  // keeping only the upper half treats the second word as a binary fraction
  function automatic logic [DW-1:0] lmr_mul(input logic [DW-1:0] a, input logic [DW-1:0] b);
    logic [PW-1:0] p;
    p = PW'(a) * PW'(b);
    return p[PW-1:DW];
  endfunction

  logic [AW-1:0] avg_i;
  logic [AW-1:0] avg_p;
  logic [DW-1:0] inst_p;
  logic [AW-1:0] blend_num;
  logic [DW-1:0] blend;
  logic [DW-1:0] rise_cap;
  logic [DW-1:0] fall_cap;
  logic [DW-1:0] filt_out;

  ////////////////////////////////////////////////////////////////////////////
  // running averages and arithmetic terms, all divisions truncate
  // the averages divide by the sample count every cycle; a zero count
  // (no sample yet) reads as a zero average
  always_comb begin
    inst_p = lmr_mul(mean_current_reading, voltage_reading);
    filt_out = r_r.filt[FW-1:FILT_SHIFT];
    avg_i = AW'(lmr_div(r_r.acc_i, AW'(r_r.n_samp)));
    avg_p = AW'(lmr_div(r_r.acc_p, AW'(r_r.n_samp)));
    blend_num = AW'(PW'(r_r.old_q) * PW'(r_r.weight))
      + AW'(PW'(r_r.new_q) * PW'(LMR_WEIGHT_FULL - r_r.weight));
    blend = lmr_div(blend_num, AW'(LMR_WEIGHT_FULL));
    rise_cap = lmr_div(AW'(PW'(r_r.old_q) * PW'(r_r.rise)), AW'(LMR_FACTOR_DIV));
    fall_cap = lmr_div(AW'(PW'(r_r.old_q) * PW'(r_r.fall)), AW'(LMR_FACTOR_DIV));
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for configuration, averaging, load choice and update engine
  // every field defaults to its present value, the pulses to zero
  always_comb begin
    r_nxt = r_r;
    r_nxt.resim = 1'b0;
    r_nxt.done = 1'b0;

    // configuration writes; weight spans two bytes, low byte first
    // a host writing the weight as two bytes sees a mixed value in between
    if (cfg_wr) begin
      case (cfg_addr)
        LMR_OFF_SELECTOR: r_nxt.selector = cfg_wdata;
        LMR_OFF_KIND: r_nxt.kind = cfg_wdata;
        LMR_OFF_RISE: r_nxt.rise = cfg_wdata;
        LMR_OFF_FALL: r_nxt.fall = cfg_wdata;
        LMR_OFF_WEIGHT_LO: r_nxt.weight[7:0] = cfg_wdata;
        LMR_OFF_WEIGHT_HI: r_nxt.weight[15:8] = cfg_wdata;
        default: r_nxt.weight = r_r.weight;
      endcase
    end

    // read-back; unmapped offsets read zero
    case (cfg_addr)
      LMR_OFF_SELECTOR: r_nxt.rdata = r_r.selector;
      LMR_OFF_KIND: r_nxt.rdata = r_r.kind;
      LMR_OFF_RISE: r_nxt.rdata = r_r.rise;
      LMR_OFF_FALL: r_nxt.rdata = r_r.fall;
      LMR_OFF_WEIGHT_LO: r_nxt.rdata = r_r.weight[7:0];
      LMR_OFF_WEIGHT_HI: r_nxt.rdata = r_r.weight[15:8];
      default: r_nxt.rdata = 8'h00;
    endcase

    // first-order filter of mean current; shift sets the time constant in samples
    // state settles at 2**FILT_SHIFT times the input, so its upper bits give
    // the filtered reading with no dead band around small steps
    if (sample_valid) begin
      r_nxt.filt = r_r.filt - (r_r.filt >> FILT_SHIFT) + FW'(mean_current_reading);
    end

    // running discharge averages; a fresh discharge restarts them
    // the count saturates, so an endless discharge freezes the average
    r_nxt.was_dis = discharging;
    if (discharging) begin
      if (!r_r.was_dis) begin
        r_nxt.acc_i = '0;
        r_nxt.acc_p = '0;
        r_nxt.n_samp = '0;
        r_nxt.dis_cnt = '0;
        r_nxt.live = 1'b0;
      end else begin
        if (sample_valid && r_r.n_samp != '1) begin
          r_nxt.acc_i = r_r.acc_i + AW'(mean_current_reading);
          r_nxt.acc_p = r_r.acc_p + AW'(inst_p);
          r_nxt.n_samp = r_r.n_samp + 32'h1;
        end
        if (!r_r.live) begin
          r_nxt.dis_cnt = r_r.dis_cnt + 64'h1;
          if (r_r.dis_cnt >= 64'(RESIM_CYC - 1)) begin
            r_nxt.live = 1'b1;
            r_nxt.resim = 1'b1;
          end
        end
      end
    end else begin
      r_nxt.live = 1'b0;
      if (r_r.was_dis && r_r.n_samp != '0) begin
        r_nxt.last_i = avg_i[DW-1:0];
        r_nxt.last_p = avg_p[DW-1:0];
      end
    end

    // load selection; unknown selectors hold the previous choice
    // the stored last-run value stands in until the live average is trusted
    if (r_r.kind[0] == 1'b0) begin
      case (r_r.selector[2:0])
        LMR_SEL_PREV: r_nxt.load = r_r.last_i;
        LMR_SEL_RUN: r_nxt.load = r_r.live ? avg_i[DW-1:0] : r_r.last_i;
        LMR_SEL_MEAN: r_nxt.load = mean_current_reading;
        LMR_SEL_FILT: r_nxt.load = filt_out;
        LMR_SEL_DESIGN: r_nxt.load = design_capacity / DW'(LMR_RATE_DIV);
        LMR_SEL_HOST: r_nxt.load = host_load_setting;
        LMR_SEL_USER: r_nxt.load = user_current_setting;
        default: r_nxt.load = r_r.load;
      endcase
    end else begin
      case (r_r.selector[2:0])
        LMR_SEL_PREV: r_nxt.load = r_r.last_p;
        LMR_SEL_RUN: r_nxt.load = r_r.live ? avg_p[DW-1:0] : r_r.last_p;
        LMR_SEL_MEAN: r_nxt.load = inst_p;
        LMR_SEL_FILT: r_nxt.load = lmr_mul(filt_out, voltage_reading);
        LMR_SEL_DESIGN: r_nxt.load = design_energy / DW'(LMR_RATE_DIV);
        LMR_SEL_HOST: r_nxt.load = host_load_setting;
        LMR_SEL_USER: r_nxt.load = user_power_setting;
        default: r_nxt.load = r_r.load;
      endcase
    end
    // selector codes above six are refused and leave the load as it was
    if (r_r.selector > 8'h06) begin
      r_nxt.load = r_r.load;
    end

    // two-step update: capture, then blend and clamp in one cycle
    // a start while busy is ignored; the operands stay captured until done
    case (r_r.st)
      LMR_ST_IDLE: begin
        if (res_start) begin
          r_nxt.old_q = res_old;
          r_nxt.new_q = res_new;
          r_nxt.st = LMR_ST_CALC;
        end
      end
      LMR_ST_CALC: begin
        if (blend > r_r.old_q) begin
          r_nxt.result = (blend < rise_cap) ? blend : rise_cap;
        end else if (blend < r_r.old_q) begin
          r_nxt.result = (blend > fall_cap) ? blend : fall_cap;
        end else begin
          // equal values pass straight through
          r_nxt.result = blend;
        end
        r_nxt.st = LMR_ST_DONE;
      end
      LMR_ST_DONE: begin
        r_nxt.done = 1'b1;
        r_nxt.st = LMR_ST_IDLE;
      end
      default: r_nxt.st = LMR_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; synchronous reset to power-on defaults
  // the whole record clears first, then the configuration bytes take their
  // power-on values; everything else, outputs included, starts at zero
  always_ff @(posedge clk) begin
    if (reset) begin
      r_r <= '0;
      r_r.selector <= LMR_RST_SELECTOR;
      r_r.kind <= LMR_RST_KIND;
      r_r.rise <= LMR_RST_RISE;
      r_r.fall <= LMR_RST_FALL;
      r_r.weight <= LMR_RST_WEIGHT;
      r_r.st <= LMR_ST_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  // no logic follows the register, so no output changes before the clock edge that follows its cause
  assign cfg_rdata = r_r.rdata;
  assign load_kind_flag = r_r.kind[0];
  assign sim_load = r_r.load;
  assign resim_pulse = r_r.resim;
  assign last_run_current = r_r.last_i;
  assign last_run_power = r_r.last_p;
  assign res_result = r_r.result;
  assign res_done = r_r.done;

endmodule // lmr_load_model

//--- lmr_load_model_checker.sv
// assertion checker for the load model and resistance update block
module lmr_load_model_checker
  import lmr_pkg::*;
#(
  parameter int DW = 16,
  parameter longint RESIM_CYC = LMR_RESIM_CYC
) (
  input wire logic clk, reset, cfg_wr, load_kind_flag, discharging, sample_valid,
  input wire logic res_start, resim_pulse, res_done,
  input wire logic [6:0] cfg_addr,
  input wire logic [7:0] cfg_wdata, cfg_rdata,
  input wire logic [DW-1:0] mean_current_reading, voltage_reading, design_capacity,
  input wire logic [DW-1:0] design_energy, host_load_setting, user_current_setting,
  input wire logic [DW-1:0] user_power_setting, sim_load, last_run_current, last_run_power,
  input wire logic [DW-1:0] res_old, res_new, res_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sel_r, sel_nxt;
  logic [DW-1:0] old_r, new_r, old_nxt, new_nxt;
  ////////////////////////////////////////////////////////////////////////////////
  // mirror the selector and the update operands, since neither is visible at the ports
  always_comb begin
    sel_nxt = (cfg_wr && cfg_addr == LMR_OFF_SELECTOR) ? cfg_wdata : sel_r;
    {old_nxt, new_nxt} = res_start ? {res_old, res_new} : {old_r, new_r};
  end
  always_ff @(posedge clk) begin
    sel_r <= reset ? LMR_RST_SELECTOR : sel_nxt;
    old_r <= old_nxt;
    new_r <= new_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  kind_flag_a: assert property (cfg_wr && cfg_addr == LMR_OFF_KIND |=>
    load_kind_flag == $past(cfg_wdata[0])) else $error("kind flag off");
  load_host_a: assert property (sel_r == 8'h05 |=>
    sim_load == $past(host_load_setting)) else $error("host load not chosen");
  load_user_a: assert property (sel_r == 8'h06 && !load_kind_flag |=>
    sim_load == $past(user_current_setting)) else $error("user current not chosen");
  done_latency_a: assert property ($rose(res_start) |-> ##[2:4] res_done)
    else $error("update never done");
  rise_bound_a: assert property (res_done && new_r > old_r |->
    res_result >= old_r && res_result <= new_r) else $error("rise result out of range");
  fall_bound_a: assert property (res_done && new_r < old_r |->
    res_result <= old_r && res_result >= new_r) else $error("fall result out of range");
  equal_keep_a: assert property (res_done && new_r == old_r |-> res_result == old_r)
    else $error("equal update changed value");
  resim_once_a: assert property (resim_pulse |-> $past(discharging) ##1 !resim_pulse)
    else $error("resim pulse bad");
  last_hold_a: assert property (discharging |=>
    $stable(last_run_current) && $stable(last_run_power)) else $error("last run moved");
  // main scenarios reached
  cover property (res_done);
  cover property (resim_pulse);
  cover property (load_kind_flag && sel_r == 8'h06);
endmodule // lmr_load_model_checker

bind lmr_load_model lmr_load_model_checker #(.DW(DW), .RESIM_CYC(RESIM_CYC))
  lmr_load_model_checker_inst (.*);

//--- testbench.sv
// self-checking bench for the load model and resistance update block
module testbench
  import lmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, cfg_wr, load_kind_flag, discharging, sample_valid;
  logic res_start, resim_pulse, res_done;
  logic [6:0] cfg_addr;
  logic [7:0] cfg_wdata, cfg_rdata;
  logic [15:0] mean_current_reading, voltage_reading, design_capacity, design_energy;
  logic [15:0] host_load_setting, user_current_setting, user_power_setting, sim_load;
  logic [15:0] last_run_current, last_run_power, res_old, res_new, res_result;
  int errors, n_tests, pulses;
  // address and reset byte; 0x02 is unmapped
  logic [15:0] regs [7] = '{16'h0001, 16'h0101, 16'h110F, 16'h1205, 16'h1420, 16'h1503, 16'h0200};
  // kind, selector, expected load
  logic [31:0] rows [8] = '{32'h0002_0064, 32'h0004_0064, 32'h0005_004D, 32'h0006_0042,
    32'h0102_0032, 32'h0104_00C8, 32'h0105_004D, 32'h0106_0037};
  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
  lmr_load_model #(.DW(16), .RESIM_CYC(20), .FILT_SHIFT(2)) lmr_load_model_inst (.*);
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_wr = 1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 0;
  endtask
  // one update; waits bounded, since a hung engine must not stall the run
  task automatic upd(input logic [15:0] o, n, e);
    @(negedge clk);
    res_start = 1;
    res_old = o;
    res_new = n;
    @(negedge clk);
    res_start = 0;
    for (int i = 0; i < 10 && res_done !== 1'b1; i++) @(negedge clk);
    `CHK("res_done", 1'b1, res_done)
    `CHK("res_result", e, res_result)
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {cfg_wr, discharging, sample_valid, res_start, cfg_wdata, res_old, res_new} = '0;
    cfg_addr = 7'h02;
    mean_current_reading = 16'h0064;
    voltage_reading = 16'h8000;
    design_capacity = 16'h01F4;
    design_energy = 16'h03E8;
    host_load_setting = 16'h004D;
    user_current_setting = 16'h0042;
    user_power_setting = 16'h0037;
    reset = 1;
    repeat (10) @(negedge clk);
    reset = 0;
    `CHK("load_kind_flag", 1'b1, load_kind_flag)
    foreach (regs[i]) begin
      cfg_addr = regs[i][14:8];
      @(negedge clk);
      `CHK("cfg_rdata", regs[i][7:0], cfg_rdata)
    end
    // fixed-source selections in both models
    foreach (rows[i]) begin
      wr(LMR_OFF_KIND, rows[i][31:24]);
      wr(LMR_OFF_SELECTOR, rows[i][23:16]);
      @(negedge clk);
      `CHK("sim_load", rows[i][15:0], sim_load)
      `CHK("load_kind_flag", rows[i][24], load_kind_flag)
    end
    wr(LMR_OFF_SELECTOR, 8'h07);
    @(negedge clk);
    `CHK("sim_load", 16'h0037, sim_load)
    // running average: stored value first, live value after the resimulation point
    wr(LMR_OFF_KIND, 8'h00);
    wr(LMR_OFF_SELECTOR, 8'h01);
    @(negedge clk);
    `CHK("sim_load", 16'h0000, sim_load)
    discharging = 1;
    pulses = 0;
    repeat (40) begin
      @(negedge clk);
      sample_valid = ~sample_valid;
      pulses += int'(resim_pulse);
    end
    `CHK("resim_pulse", 1, pulses)
    `CHK("sim_load", 16'h0064, sim_load)
    discharging = 0;
    sample_valid = 0;
    repeat (3) @(negedge clk);
    `CHK("last_run_current", 16'h0064, last_run_current)
    `CHK("last_run_power", 16'h0032, last_run_power)
    // twenty samples of a constant reading have settled the filter on it
    wr(LMR_OFF_KIND, 8'h00);
    wr(LMR_OFF_SELECTOR, 8'h03);
    @(negedge clk);
    `CHK("sim_load", 16'h0064, sim_load)
    wr(LMR_OFF_KIND, 8'h01);
    @(negedge clk);
    `CHK("sim_load", 16'h0032, sim_load)
    wr(LMR_OFF_SELECTOR, 8'h00);
    @(negedge clk);
    `CHK("sim_load", 16'h0032, sim_load)
    wr(LMR_OFF_KIND, 8'h00);
    @(negedge clk);
    `CHK("sim_load", 16'h0064, sim_load)
    // blend and clamp at default weight, then with all weight on the new value
    upd(16'h03E8, 16'h07D0, 16'h04B0);
    upd(16'h03E8, 16'h1388, 16'h05DC);
    upd(16'h0007, 16'h0000, 16'h0005);
    upd(16'h03E8, 16'h03E8, 16'h03E8);
    wr(LMR_OFF_WEIGHT_LO, 8'h00);
    wr(LMR_OFF_WEIGHT_HI, 8'h00);
    upd(16'h03E8, 16'h0064, 16'h01F4);
    upd(16'h03E8, 16'h0BB8, 16'h05DC);
    // reset in mid-run restores the configuration defaults
    reset = 1;
    repeat (2) @(negedge clk);
    reset = 0;
    cfg_addr = LMR_OFF_WEIGHT_LO;
    @(negedge clk);
    `CHK("cfg_rdata", 8'h20, cfg_rdata)
    `CHK("load_kind_flag", 1'b1, load_kind_flag)
    `CHK("sim_load", 16'h0000, sim_load)
    wrap_up();
  end
  // watchdog: the sequence needs about 150 cycles
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule // testbench
